// ---- hdl/rx_cfg_rearm.sv ----
// Receive configuration register, wait timeout and receiver re-arm control
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module rx_cfg_rearm
  import rx_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic frame_good,
  input wire logic frame_fail,
  input wire logic ack_tx_done,
  output logic rx_on,
  output logic long_delim,
  output logic low_rate_decode,
  output logic ack_gen_en,
  output logic ack_frame_pending,
  output logic irq
);
  logic [31:0] sys_cfg;
  logic [15:0] wait_period;
  logic [15:0] wait_count;
  logic [ev_width-1:0] ev_status;
  logic [ev_width-1:0] ev_mask;
  logic dbl_buf;
  rx_state_t state;

  // Address match shared by every register write decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  // Register decode
  wire cfg_wr = reg_wr && addr_hit(reg_addr, sys_cfg_addr);
  wire ctrl_wr = reg_wr && addr_hit(reg_addr, sys_ctrl_addr);
  wire period_wr = reg_wr && addr_hit(reg_addr, wait_period_addr);
  wire stat_wr = reg_wr && addr_hit(reg_addr, event_status_addr);
  wire mask_wr = reg_wr && addr_hit(reg_addr, event_mask_addr);
  wire rx_enable_cmd = ctrl_wr && reg_wdata[rx_enable_cmd_bit];
  wire rx_disable_cmd = ctrl_wr && reg_wdata[rx_disable_cmd_bit];
  wire cfg_low_rate = sys_cfg[rx_low_rate_mode_bit];
  wire cfg_wto_en = sys_cfg[rx_wait_timeout_en_bit];
  wire cfg_rearm = sys_cfg[rx_auto_rearm_bit];
  wire cfg_ack = sys_cfg[auto_ack_en_bit];
  wire listening = (state == rx_listen);

  // Frame and timeout events only count while the receiver is listening; the ack event only in the ack wait state
  wire got_good = listening && frame_good;
  wire got_fail = listening && frame_fail && !frame_good;
  wire got_timeout = listening && cfg_wto_en && (wait_count == 16'h0001) && !frame_good
    && !frame_fail; // RULE_04
  wire got_ack = (state == rx_ack_wait) && ack_tx_done;

  // Re-arm decisions; timeouts never re-arm
  wire rearm_good = cfg_rearm && dbl_buf && !cfg_ack; // RULE_08
  wire wait_ack = dbl_buf && cfg_ack; // RULE_10
  wire rearm_fail = cfg_rearm; // RULE_08 RULE_09
  wire rearm_ack = cfg_rearm; // RULE_10

  // Receiver state
  rx_state_t next_state;
  always_comb
  begin
    next_state = state;
    unique case (state)
      rx_idle:
        // Only a host command leaves idle
        if (rx_enable_cmd)
        begin
          next_state = rx_listen; // RULE_07
        end
      rx_listen:
        if (rx_disable_cmd)
        begin
          next_state = rx_idle;
        end
        else if (got_timeout)
        begin
          // Timeout switches off even with re-arm set
          next_state = rx_idle; // RULE_04 RULE_08 RULE_09
        end
        else if (got_good)
        begin
          // A good frame waits for the acknowledge when double-buffered with auto acknowledge, else drops to idle unless re-arm applies
          if (wait_ack)
          begin
            next_state = rx_ack_wait;
          end
          else
          begin
            next_state = rearm_good ? rx_listen : rx_idle; // RULE_06 RULE_08 RULE_09
          end
        end
        else if (got_fail)
        begin
          // Failures re-arm in both buffer modes
          next_state = rearm_fail ? rx_listen : rx_idle; // RULE_06 RULE_09
        end
      rx_ack_wait:
        // Receiver stays off while the acknowledge goes out
        if (rx_disable_cmd)
        begin
          next_state = rx_idle;
        end
        else if (got_ack)
        begin
          next_state = rearm_ack ? rx_listen : rx_idle; // RULE_10
        end
    endcase
  end

  // Countdown restarts on each entry to listening, including a re-arm
  // A period of zero never reaches one, so it never times out
  wire restart = (next_state == rx_listen) && (!listening || got_good || got_fail);
  logic [15:0] next_wait_count;
  assign next_wait_count = restart ? wait_period
    : ((listening && wait_count != 16'h0000) ? wait_count - 16'h0001 : wait_count);

  // Sticky events: set wins over write-one-to-clear
  logic [ev_width-1:0] ev_set;
  assign ev_set = {got_ack, got_timeout, got_fail, got_good}; // RULE_05
  wire [ev_width-1:0] next_ev_status;
  // Same cell for every event bit, so the bits cannot drift apart
  genvar ev_i;
  generate
    for (ev_i = 0; ev_i < ev_width; ev_i = ev_i + 1)
    begin : g_sticky
      wire clear_bit = stat_wr && reg_wdata[ev_i];
      assign next_ev_status[ev_i] = ev_set[ev_i] || (ev_status[ev_i] && !clear_bit);
    end
  endgenerate

  // Read views of the narrow registers, zero-extended to the bus width
  wire [31:0] rd_period = {16'h0000, wait_period};
  wire [31:0] rd_status = {28'h0000000, ev_status};
  wire [31:0] rd_mask = {28'h0000000, ev_mask};
  wire [31:0] rd_ctrl = {19'h00000, dbl_buf, 12'h000};
  wire [31:0] rd_state = {14'h0000, wait_count, state == rx_ack_wait, listening};

  // Read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      sys_cfg_addr: rd_mux = sys_cfg;
      wait_period_addr: rd_mux = rd_period;
      event_status_addr: rd_mux = rd_status;
      event_mask_addr: rd_mux = rd_mask;
      sys_ctrl_addr: rd_mux = rd_ctrl;
      rx_state_addr: rd_mux = rd_state;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Next values of the registered outputs; irq follows the updated status
  wire [31:0] next_reg_rdata = reg_rd ? rd_mux : 32'h0000_0000;
  wire next_rx_on = (next_state == rx_listen);
  wire next_irq = |(next_ev_status & ev_mask);

  // Configuration word; reserved bits 27..23 kept at zero whatever is written
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sys_cfg <= sys_cfg_reset; // RULE_11 RULE_12
    end
    else if (cfg_wr)
    begin
      sys_cfg <= reg_wdata & sys_cfg_writable; // RULE_03
    end
  end

  // Frame wait period, in core clock cycles
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_period <= wait_period_reset;
    end
    else if (period_wr)
    begin
      wait_period <= reg_wdata[15:0];
    end
  end

  // Interrupt mask, same layout as the status
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ev_mask <= '0;
    end
    else if (mask_wr)
    begin
      ev_mask <= reg_wdata[ev_width-1:0];
    end
  end

  // Buffer mode, stored on every control write
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dbl_buf <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      dbl_buf <= reg_wdata[dbl_buf_bit];
    end
  end

  // Receiver state
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= rx_idle;
    end
    else
    begin
      state <= next_state; // RULE_07
    end
  end

  // Frame wait countdown
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_count <= 16'h0000;
    end
    else
    begin
      wait_count <= next_wait_count; // RULE_04
    end
  end

  // Sticky event status
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ev_status <= '0;
    end
    else
    begin
      ev_status <= next_ev_status; // RULE_05
    end
  end

  // Read data, zero outside the answer cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Receiver enable, from the next state so it moves with the state
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_on <= 1'b0;
    end
    else
    begin
      rx_on <= next_rx_on; // RULE_06
    end
  end

  // Delimiter search select
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      long_delim <= 1'b0;
    end
    else
    begin
      long_delim <= cfg_low_rate; // RULE_01 RULE_02
    end
  end

  // Low-rate decode select
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_rate_decode <= 1'b0;
    end
    else
    begin
      low_rate_decode <= cfg_low_rate; // RULE_01 RULE_02
    end
  end

  // Automatic acknowledge enable
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_gen_en <= 1'b0;
    end
    else
    begin
      ack_gen_en <= cfg_ack; // RULE_11
    end
  end

  // Frame-pending value for generated acknowledges
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_frame_pending <= 1'b0;
    end
    else
    begin
      ack_frame_pending <= sys_cfg[auto_ack_pending_bit]; // RULE_12
    end
  end

  // Level interrupt
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= next_irq;
    end
  end
endmodule // rx_cfg_rearm

// ---- hdl/rx_cfg_pkg.sv ----
// Constants and types for the receive configuration and re-arm block
// Summary of operation
// RULE_01: Low-rate bit set: search long delimiter, decode header and data at 110 kbps.
// RULE_02: Low-rate bit clear: short delimiter, payload rate taken from received header.
// RULE_03: Software writes zero to reserved configuration bits 27 to 23.
// RULE_04: Timeout enabled: each receive enable starts countdown; expiry switches receiver off.
// RULE_05: Countdown expiry sets the receive timeout event flag.
// RULE_06: Re-arm bit clear: any receive event, good or bad, returns to idle.
// RULE_07: Without re-arm, host sets receive enable command again for more reception.
// RULE_08: Double-buffered with re-arm: re-arm after any frame or failure, not timeout.
// RULE_09: Single-buffered with re-arm: re-arm only after failure, never after timeout.
// RULE_10: Double-buffered with auto acknowledge: re-arm only after the acknowledge is sent.
// RULE_11: Configuration bit 30 enables automatic acknowledge, reset value zero.
// RULE_12: Pending configuration bit is copied into generated acknowledge frame-pending bit.
package rx_cfg_pkg;
  localparam logic [7:0] sys_cfg_addr = 8'h04;
  localparam logic [7:0] sys_ctrl_addr = 8'h0d;
  localparam logic [7:0] wait_period_addr = 8'h0c;
  localparam logic [7:0] event_status_addr = 8'h0f;
  localparam logic [7:0] event_mask_addr = 8'h0e;
  localparam logic [7:0] rx_state_addr = 8'h10;
  localparam int rx_low_rate_mode_bit = 22;
  localparam int rx_wait_timeout_en_bit = 28;
  localparam int rx_auto_rearm_bit = 29;
  localparam int auto_ack_en_bit = 30;
  localparam int auto_ack_pending_bit = 31;
  localparam int dbl_buf_bit = 12;
  localparam int rx_enable_cmd_bit = 8;
  localparam int rx_disable_cmd_bit = 6;
  localparam logic [31:0] sys_cfg_reset = 32'h0000_0000;
  localparam logic [31:0] sys_cfg_writable = 32'hf07f_ffff;
  localparam logic [15:0] wait_period_reset = 16'h0000;
  localparam int ev_good_frame = 0;
  localparam int ev_rx_failure = 1;
  localparam int ev_timeout = 2;
  localparam int ev_ack_done = 3;
  localparam int ev_width = 4;
  typedef enum logic [1:0] {delim_short, delim_long} delim_t;
  typedef enum {rx_idle, rx_listen, rx_ack_wait} rx_state_t;
endpackage

// ---- tb/far_end.sv ----
// Remote transmitter model delivering receive events and ack completion
`timescale 1ns/10ps
module far_end
(
  input wire logic core_clk,
  output logic frame_good,
  output logic frame_fail,
  output logic ack_tx_done
);
  initial {frame_good, frame_fail, ack_tx_done} = 3'h0;
  // Kind 0 good, 1 failure, 2 ack sent, other none; drives on a rising edge
  task automatic send(input int k, input int d);
    repeat (d + 1) @(posedge core_clk);
    frame_good <= (k == 0);
    frame_fail <= (k == 1);
    ack_tx_done <= (k == 2);
    @(posedge core_clk);
    {frame_good, frame_fail, ack_tx_done} <= 3'h0;
  endtask
endmodule // far_end

// ---- tb/rx_cfg_sva.sv ----
// Port checker for the receive configuration block
`timescale 1ns/10ps
module rx_cfg_sva
  import rx_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic frame_good,
  input wire logic frame_fail,
  input wire logic rx_on,
  input wire logic long_delim,
  input wire logic low_rate_decode,
  input wire logic ack_gen_en,
  input wire logic ack_frame_pending
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire cw = reg_wr && reg_addr == sys_cfg_addr;
  logic arm;
  // Mirror of the re-arm bit, since the checker cannot see the register
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      arm <= 1'b0;
    else if (cw)
      arm <= reg_wdata[29];
  a_delim_cfg: assert property (cw |=> ##1 long_delim == $past(reg_wdata[22], 2))
    else $error("delimiter select wrong");
  a_rate_hold: assert property (!cw |=> ##1 $stable(low_rate_decode))
    else $error("rate mode moved");
  a_ack_cfg: assert property (cw |=> ##1 ack_gen_en == $past(reg_wdata[30], 2))
    else $error("ack enable wrong");
  a_pend_cfg: assert property (cw |=> ##1 ack_frame_pending == $past(reg_wdata[31], 2))
    else $error("pending copy wrong");
  a_rsvd_read: assert property (reg_rd && reg_addr == sys_cfg_addr |=> reg_rdata[27:23] == 5'h00)
    else $error("reserved bits read back");
  a_enable_on: assert property (reg_wr && reg_addr == sys_ctrl_addr && reg_wdata[8] && !reg_wdata[6]
    |=> rx_on)
    else $error("enable ignored");
  a_idle_event: assert property (rx_on && (frame_good || frame_fail) && !arm && !reg_wr |=> !rx_on)
    else $error("receiver stayed on");
  a_fail_rearm: assert property (rx_on && frame_fail && !frame_good && arm && !reg_wr |=> rx_on)
    else $error("no re-arm on failure");
  c_off: cover property (rx_on ##1 !rx_on);
  c_fail_arm: cover property (frame_fail && arm);
  c_cfg: cover property (cw);
endmodule // rx_cfg_sva
bind rx_cfg_rearm rx_cfg_sva chk (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .frame_good, .frame_fail, .rx_on, .long_delim, .low_rate_decode, .ack_gen_en,
  .ack_frame_pending);

// ---- tb/rx_cfg_rearm_tb.sv ----
// Self-checking bench for the receive configuration block
`timescale 1ns/10ps
module rx_cfg_rearm_tb;
  import rx_cfg_pkg::*;
  logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic frame_good, frame_fail, ack_tx_done, rx_on, long_delim, low_rate_decode;
  logic ack_gen_en, ack_frame_pending, irq;
  int error_cnt = 0, checked = 0;
  rx_cfg_rearm dut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frame_good, .frame_fail, .ack_tx_done, .rx_on, .long_delim, .low_rate_decode,
    .ack_gen_en, .ack_frame_pending, .irq);
  far_end p (.core_clk, .frame_good, .frame_fail, .ack_tx_done);
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  // Gap cycle between strobes so no signal is driven twice in one step
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task s_cfg;
    rd(sys_cfg_addr, 32'h0);
    chk({ack_gen_en, ack_frame_pending, long_delim}, 3'h0);
    wr(sys_cfg_addr, 32'hf07f_ffff);
    rd(sys_cfg_addr, 32'hf07f_ffff);
    chk({ack_gen_en, ack_frame_pending, long_delim, low_rate_decode}, 4'hf);
    rd(8'h20, 32'h0);
  endtask
  task s_timeout;
    int n;
    wr(wait_period_addr, 32'h5);
    wr(event_mask_addr, 32'h4);
    wr(sys_cfg_addr, 32'h1000_0000);
    wr(sys_ctrl_addr, 32'h100);
    n = 0;
    #1;
    while (rx_on === 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(n, 5);
    if (n == 20)
      report_and_stop;
    rd(event_status_addr, 32'h4);
    chk(irq, 1'b1);
    wr(event_mask_addr, 32'h0);
    rd(event_mask_addr, 32'h0);
    chk(irq, 1'b0);
    wr(event_status_addr, 32'h4);
    wr(event_mask_addr, 32'h4);
    rd(event_status_addr, 32'h0);
    chk(irq, 1'b0);
  endtask
  // Idle, configure, enable, then one far-end send of kind k (kind 3 sends no event)
  task rearm_case(input logic [31:0] cfg, input logic [31:0] ctl, input int k, input logic e);
    wr(sys_ctrl_addr, 32'h40);
    wr(sys_cfg_addr, cfg);
    wr(sys_ctrl_addr, ctl | 32'h100);
    #1 chk(rx_on, 1'b1);
    p.send(k, k);
    #1 chk(rx_on, e);
  endtask
  task s_ack;
    rearm_case(32'h6000_0000, 32'h1000, 0, 1'b0);
    p.send(2, 3);
    #1 chk(rx_on, 1'b1);
  endtask
  task report_and_stop;
    $display("errors %0d of checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    s_cfg;
    s_timeout;
    rearm_case(32'h0, 32'h0, 0, 1'b0);
    rearm_case(32'h0, 32'h0, 1, 1'b0);
    rearm_case(32'h2000_0000, 32'h0, 1, 1'b1);
    rearm_case(32'h2000_0000, 32'h1000, 0, 1'b1);
    rearm_case(32'h2000_0000, 32'h0, 0, 1'b0);
    rearm_case(32'h3000_0000, 32'h1000, 3, 1'b0);
    s_ack;
    report_and_stop;
  end
endmodule // rx_cfg_rearm_tb
